/* File: src/fwp_consts.vh */
// Constants for the flash program controller: command codes, status bits, timing.
// Assumes a 250 MHz controller clock and an asynchronous x16 flash bus.
`ifndef FWP_CONSTS_VH
`define FWP_CONSTS_VH
`define FWP_CMD_PROG        8'h40
`define FWP_CMD_PROG_ALT    8'h10
`define FWP_CMD_BUF_SETUP   8'hE8
`define FWP_CMD_CONFIRM     8'hD0
`define FWP_CMD_READ_ARRAY  8'hFF
`define FWP_CMD_READ_STATUS 8'h70
`define FWP_CMD_CLR_STATUS  8'h50
`define FWP_MAX_COUNT_M1    4'hF
`define FWP_BIT_READY       7
`define FWP_BIT_ERASE_ERR   5
`define FWP_BIT_PROG_ERR    4
`define FWP_BIT_SUPPLY_ERR  3
`define FWP_BIT_PROTECT_ERR 1
`define FWP_BIT_BUF_AVAIL   7
`define FWP_CLK_PERIOD_PS   4000
`define FWP_T_WE_LOW_PS     60000
`define FWP_T_WE_HIGH_PS    30000
`define FWP_T_READ_PS       90000
`endif

/* File: src/fwp_bus_cycle.v */
// Single asynchronous flash bus cycle: one write or one read, timed in clock cycles.
// Assumes a flash data bus driven through separate in/out/enable signals.
`timescale 1ns/1ps
`default_nettype none
`include "fwp_consts.vh"
module fwp_bus_cycle #(
    parameter AW = 23
) (
    input  wire          i_clk,     // Clock
    input  wire          i_arst_n,  // Async reset, low
    input  wire          i_start,   // Begin cycle pulse
    input  wire          i_write,   // 1 write, 0 read
    input  wire [AW-1:0] i_addr,    // Cycle address
    input  wire [15:0]   i_wdata,   // Write data
    input  wire [15:0]   i_dq_in,   // Flash data pins in
    output reg           o_done,    // Cycle finished pulse
    output reg  [15:0]   o_rdata,   // Read data
    output reg  [AW-1:0] o_addr,    // Flash address pins
    output reg  [15:0]   o_dq_out,  // Flash data pins out
    output reg           o_dq_oe_n, // Data drive enable, low drives
    output reg           o_ce_n,    // Chip enable
    output reg           o_we_n,    // Write enable
    output reg           o_oe_n     // Output enable
);
    // Strobe times rounded up to whole clocks, then cut to the counter width
    localparam WE_LOW_CLKS  = (`FWP_T_WE_LOW_PS + `FWP_CLK_PERIOD_PS - 1) / `FWP_CLK_PERIOD_PS;
    localparam WE_HIGH_CLKS = (`FWP_T_WE_HIGH_PS + `FWP_CLK_PERIOD_PS - 1) / `FWP_CLK_PERIOD_PS;
    localparam RD_WAIT_CLKS = (`FWP_T_READ_PS + `FWP_CLK_PERIOD_PS - 1) / `FWP_CLK_PERIOD_PS;
    localparam [7:0] WE_LOW  = WE_LOW_CLKS[7:0];
    localparam [7:0] WE_HIGH = WE_HIGH_CLKS[7:0];
    localparam [7:0] RD_WAIT = RD_WAIT_CLKS[7:0];
    localparam [1:0] S_IDLE = 2'h0, S_ACT = 2'h1, S_REC = 2'h2;
    reg [1:0]  state_ff;
    reg [7:0]  cnt_ff;
    reg        wr_ff;
    reg [15:0] dq_s1_ff, dq_s2_ff;
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            dq_s1_ff <= 16'h0000;
            dq_s2_ff <= 16'h0000;
        end else begin
            dq_s1_ff <= i_dq_in;
            dq_s2_ff <= dq_s1_ff;
        end
    end
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_ff  <= S_IDLE;
            cnt_ff    <= 8'h00;
            wr_ff     <= 1'b0;
            o_done    <= 1'b0;
            o_rdata   <= 16'h0000;
            o_addr    <= {AW{1'b0}};
            o_dq_out  <= 16'h0000;
            o_dq_oe_n <= 1'b1;
            o_ce_n    <= 1'b1;
            o_we_n    <= 1'b1;
            o_oe_n    <= 1'b1;
        end else begin
            o_done <= 1'b0;
            case (state_ff)
                S_IDLE: begin
                    if (i_start) begin
                        state_ff  <= S_ACT;
                        wr_ff     <= i_write;
                        o_addr    <= i_addr;
                        o_dq_out  <= i_wdata;
                        o_dq_oe_n <= ~i_write;
                        o_ce_n    <= 1'b0;
                        o_we_n    <= ~i_write;
                        o_oe_n    <= i_write;
                        cnt_ff    <= i_write ? WE_LOW : RD_WAIT + 8'h02;
                    end
                end
                S_ACT: begin
                    if (cnt_ff != 8'h00) begin
                        cnt_ff <= cnt_ff - 8'h01;
                    end else begin
                        if (!wr_ff) begin
                            o_rdata <= dq_s2_ff;
                        end
                        o_ce_n    <= 1'b1;
                        o_we_n    <= 1'b1;
                        o_oe_n    <= 1'b1;
                        cnt_ff    <= WE_HIGH;
                        state_ff  <= S_REC;
                    end
                end
                S_REC: begin
                    if (cnt_ff != 8'h00) begin
                        cnt_ff <= cnt_ff - 8'h01;
                    end else begin
                        o_dq_oe_n <= 1'b1;
                        o_done    <= 1'b1;
                        state_ff  <= S_IDLE;
                    end
                end
                default: state_ff <= S_IDLE;
            endcase
        end
    end
endmodule // fwp_bus_cycle
`default_nettype wire

/* File: src/fwp_prog_ctrl.v */
// Host-side controller running word and page-buffer program sequences on a flash.
// Assumes the flash bus pins connect directly; user orders arrive on plain ports.
// Contract
// - Word program: command 40H or 10H at address, then address with data.
// - Only one partition programs at a time; others stay in read modes.
// - Buffer setup E8H; retry until buffer-available flag reads 1; the controller gives up with o_timeout once the poll count reaches MAX_POLLS.
// - Second cycle: count minus one, at most 0FH, else sequence error.
// - Remaining words one per cycle, addresses within start plus count.
// - Confirm D0H inside partition starts buffer transfer to array.
// - Further setup may be queued while busy if buffer available; the controller instead polls to ready and drops orders while busy.
// - Host writes FFH to return partition to array read.
// - Read-status 70H makes reads of partition return status.
`timescale 1ns/1ps
`default_nettype none
`include "fwp_consts.vh"
module fwp_prog_ctrl #(
    parameter AW = 23,
    parameter MAX_POLLS = 16'hFFFF
) (
    input  wire          i_clk,      // Clock
    input  wire          i_arst_n,   // Async reset, low
    input  wire          i_start,    // Start order pulse
    input  wire          i_buf_mode, // 1 page buffer, 0 word
    input  wire          i_alt_cmd,  // Use alternate word code
    input  wire [AW-1:0] i_addr,     // Start address
    input  wire [3:0]    i_count_m1, // Words minus one
    input  wire [15:0]   i_wdata,    // Word data
    output wire          o_wready,   // Data word accepted this cycle
    output wire          o_busy,     // Sequence running
    output reg           o_done,     // Sequence finished pulse
    output reg  [7:0]    o_status,   // Final status
    output reg           o_error,    // Any error flag seen
    output reg           o_timeout,  // Poll limit reached
    input  wire [15:0]   i_dq_in,    // Flash data in
    output wire [AW-1:0] o_f_addr,   // Flash address
    output wire [15:0]   o_dq_out,   // Flash data out
    output wire          o_dq_oe_n,  // Flash data drive, low drives
    output wire          o_ce_n,     // Flash chip enable
    output wire          o_we_n,     // Flash write enable
    output wire          o_oe_n      // Flash output enable
);
    localparam [3:0] S_IDLE = 4'h0, S_SETUP = 4'h1, S_XPOLL = 4'h2, S_COUNT = 4'h3,
                     S_DATA = 4'h4, S_CONF = 4'h5, S_POLL = 4'h6, S_CLR = 4'h7,
                     S_ARR = 4'h8, S_FIN = 4'h9, S_RSTAT = 4'hA;
    reg [3:0]    state_ff;
    reg          pend_ff;
    reg          bmode_ff, alt_ff;
    reg [AW-1:0] addr_ff;
    reg [3:0]    cnt_ff, idx_ff;
    reg [15:0]   poll_ff;
    reg          go;
    reg          wr;
    reg [AW-1:0] c_addr;
    reg [15:0]   c_data;
    wire         cyc_done;
    wire [15:0]  rdata;
    function [15:0] fwp_cmd;
        input [7:0] code;
        begin
            fwp_cmd = {8'h00, code};
        end
    endfunction
    function fwp_has_err;
        input [15:0] st;
        begin
            fwp_has_err = st[`FWP_BIT_PROG_ERR] | st[`FWP_BIT_ERASE_ERR]
                        | st[`FWP_BIT_SUPPLY_ERR] | st[`FWP_BIT_PROTECT_ERR];
        end
    endfunction
    assign o_busy   = (state_ff != S_IDLE);
    assign o_wready = (state_ff == S_DATA) & cyc_done;
    // Bus request for the current state, issued once per cycle slot
    always @* begin
        wr     = 1'b1;
        c_addr = addr_ff;
        c_data = 16'h0000;
        case (state_ff)
            S_SETUP: c_data = bmode_ff ? fwp_cmd(`FWP_CMD_BUF_SETUP)
                            : fwp_cmd(alt_ff ? `FWP_CMD_PROG_ALT : `FWP_CMD_PROG);
            S_XPOLL: wr = 1'b0;
            S_COUNT: c_data = {12'h000, cnt_ff};
            S_DATA: begin
                // Full add keeps every word between start and start plus count
                c_addr = addr_ff + {{(AW-4){1'b0}}, idx_ff};
                c_data = i_wdata;
            end
            S_CONF:  c_data = fwp_cmd(`FWP_CMD_CONFIRM);
            S_POLL:  wr = 1'b0;
            S_CLR:   c_data = fwp_cmd(`FWP_CMD_CLR_STATUS);
            S_ARR:   c_data = fwp_cmd(`FWP_CMD_READ_ARRAY);
            S_RSTAT: c_data = fwp_cmd(`FWP_CMD_READ_STATUS);
            default: c_data = 16'h0000;
        endcase
    end
    fwp_bus_cycle #(.AW(AW)) u_cyc (
        .i_clk     (i_clk),
        .i_arst_n  (i_arst_n),
        .i_start   (go),
        .i_write   (wr),
        .i_addr    (c_addr),
        .i_wdata   (c_data),
        .i_dq_in   (i_dq_in),
        .o_done    (cyc_done),
        .o_rdata   (rdata),
        .o_addr    (o_f_addr),
        .o_dq_out  (o_dq_out),
        .o_dq_oe_n (o_dq_oe_n),
        .o_ce_n    (o_ce_n),
        .o_we_n    (o_we_n),
        .o_oe_n    (o_oe_n)
    );
    always @* begin
        go = (state_ff != S_IDLE) && (state_ff != S_FIN) && !pend_ff;
    end
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_ff  <= S_IDLE;
            pend_ff   <= 1'b0;
            bmode_ff  <= 1'b0;
            alt_ff    <= 1'b0;
            addr_ff   <= {AW{1'b0}};
            cnt_ff    <= 4'h0;
            idx_ff    <= 4'h0;
            poll_ff   <= 16'h0000;
            o_done    <= 1'b0;
            o_status  <= 8'h00;
            o_error   <= 1'b0;
            o_timeout <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (go) begin
                pend_ff <= 1'b1;
            end
            case (state_ff)
                S_IDLE: begin
                    // One sequence at a time; an order that arrives while busy is dropped, not held
                    if (i_start) begin
                        bmode_ff  <= i_buf_mode;
                        alt_ff    <= i_alt_cmd;
                        addr_ff   <= i_addr;
                        cnt_ff    <= i_buf_mode ? i_count_m1 : 4'h0;
                        idx_ff    <= 4'h0;
                        poll_ff   <= 16'h0000;
                        o_error   <= 1'b0;
                        o_timeout <= 1'b0;
                        state_ff  <= S_SETUP;
                    end
                end
                S_SETUP: if (cyc_done) begin
                    pend_ff  <= 1'b0;
                    state_ff <= bmode_ff ? S_XPOLL : S_DATA;
                end
                S_XPOLL: if (cyc_done) begin
                    pend_ff <= 1'b0;
                    poll_ff <= poll_ff + 16'h0001;
                    // Buffer not free: the setup was ignored, so write it again
                    if (rdata[`FWP_BIT_BUF_AVAIL]) begin
                        state_ff <= S_COUNT;
                    end else if (poll_ff == MAX_POLLS) begin
                        o_timeout <= 1'b1;
                        state_ff  <= S_ARR;
                    end else begin
                        state_ff <= S_SETUP;
                    end
                end
                S_COUNT: if (cyc_done) begin
                    pend_ff  <= 1'b0;
                    poll_ff  <= 16'h0000;
                    state_ff <= S_DATA;
                end
                S_DATA: if (cyc_done) begin
                    pend_ff <= 1'b0;
                    idx_ff  <= idx_ff + 4'h1;
                    if (idx_ff == cnt_ff) begin
                        state_ff <= bmode_ff ? S_CONF : S_RSTAT;
                    end
                end
                S_CONF: if (cyc_done) begin
                    pend_ff  <= 1'b0;
                    state_ff <= S_RSTAT;
                end
                S_RSTAT: if (cyc_done) begin
                    pend_ff  <= 1'b0;
                    state_ff <= S_POLL;
                end
                S_POLL: if (cyc_done) begin
                    pend_ff <= 1'b0;
                    poll_ff <= poll_ff + 16'h0001;
                    if (rdata[`FWP_BIT_READY]) begin
                        o_status <= rdata[7:0];
                        o_error  <= fwp_has_err(rdata);
                        state_ff <= fwp_has_err(rdata) ? S_CLR : S_ARR;
                    end else if (poll_ff == MAX_POLLS) begin
                        o_timeout <= 1'b1;
                        state_ff  <= S_ARR;
                    end
                end
                S_CLR: if (cyc_done) begin
                    pend_ff  <= 1'b0;
                    state_ff <= S_ARR;
                end
                S_ARR: if (cyc_done) begin
                    pend_ff  <= 1'b0;
                    state_ff <= S_FIN;
                end
                S_FIN: begin
                    o_done   <= 1'b1;
                    state_ff <= S_IDLE;
                end
                default: state_ff <= S_IDLE;
            endcase
        end
    end
endmodule // fwp_prog_ctrl
`default_nettype wire

/* File: testbench/fwp_flash_model.sv */
// Flash partition model: commands, status, extended status, page buffer.
// Assumes strobes that change just after rising edges of i_clk.
`timescale 1ns/1ps
`default_nettype none
module fwp_flash_model #(
    parameter int BUSY   = 40, // Busy clocks per program
    parameter int BLK_AW = 12  // Word address bits inside one block
) (
    input  wire logic        i_clk,     // Clock
    input  wire logic [22:0] i_addr,    // Address
    input  wire logic [15:0] i_dq,      // Data bus
    input  wire logic        i_ce_n,    // Chip enable
    input  wire logic        i_we_n,    // Write enable
    input  wire logic        i_oe_n,    // Output enable
    input  wire logic        i_vpp_low, // Supply low
    input  wire logic        i_lock,    // Block locked
    input  wire logic        i_fail,    // Verify fails
    input  wire logic [1:0]  i_refuse,  // Setups refused
    output logic      [15:0] o_dq       // Read data
);
    logic [15:0] mem [16] = '{default: 16'h0000};
    logic [15:0] pb [16];
    logic [15:0] pm = 16'h0000, ld = 16'h0000, last = 16'h0000;
    logic [7:0]  cnt = 8'h00, prog_cmd = 8'h00, n_e8 = 8'h00;
    logic [6:0]  sr = 7'h00, err;
    logic [3:0]  la = 4'h0, left = 4'h0;
    logic [2:0]  st = 3'd0;
    logic [1:0]  mode = 2'd0, tries = 2'd0;
    logic        we_q = 1'b1, ok, acc;
    int          bcnt = 0, n_busy = 0, n_rs = 0;
    logic [22:0] wa = 23'h000000, sa = 23'h000000;
    assign err = {2'b00, i_vpp_low | i_lock | i_fail, i_vpp_low, 1'b0, i_lock, 1'b0};
    assign ok = !i_vpp_low && !i_lock;
    assign acc = tries >= i_refuse;
    // Released bus shows the inverse of the last word driven
    assign o_dq = (i_oe_n || i_ce_n) ? ~last : (mode == 2'd0) ? mem[i_addr[3:0]] :
        (mode == 2'd1) ? {8'h00, bcnt == 0, sr} : {8'h00, st == 3'd2, 7'h00};
    always @(posedge i_clk) begin
        we_q <= i_we_n;
        if (bcnt > 0) bcnt <= bcnt - 1;
        if (!i_we_n && !i_ce_n) begin
            la <= i_addr[3:0];
            ld <= i_dq;
            wa <= i_addr;
        end
        if (!i_oe_n && !i_ce_n) begin
            last <= o_dq;
            if (mode == 2'd1 && bcnt > 0) n_busy <= n_busy + 1;
        end
        if (!we_q && i_we_n) begin
            case (st)
                3'd1: begin
                    st <= 3'd0;
                    bcnt <= BUSY;
                    sr <= sr | err;
                    if (ok) mem[la] <= ld;
                end
                3'd2: begin
                    cnt <= ld[7:0];
                    left <= ld[3:0];
                    st <= (ld[7:0] > 8'h0F) ? 3'd0 : 3'd3;
                    if (ld[7:0] > 8'h0F) sr[5:4] <= 2'b11;
                    mode <= 2'd1;
                end
                3'd3: begin
                    pb[la] <= ld;
                    pm[la] <= 1'b1;
                    left <= left - 4'h1;
                    if (left == 4'h0) st <= 3'd4;
                    // Data outside the start block aborts the sequence
                    if ((wa >> BLK_AW) != (sa >> BLK_AW)) begin
                        sr[5:4] <= 2'b11;
                        st <= 3'd0;
                    end
                end
                3'd4: begin
                    st <= 3'd0;
                    if (ld[7:0] != 8'hD0) sr[5:4] <= 2'b11;
                    else begin
                        bcnt <= BUSY;
                        sr <= sr | err;
                        for (int i = 0; i < 16; i++) if (ok && pm[i]) mem[i] <= pb[i];
                    end
                end
                default: begin
                    case (ld[7:0])
                        8'h40, 8'h10: begin
                            st <= 3'd1;
                            prog_cmd <= ld[7:0];
                        end
                        8'hE8: begin
                            n_e8 <= n_e8 + 8'h01;
                            tries <= acc ? 2'd0 : tries + 2'd1;
                            st <= acc ? 3'd2 : 3'd0;
                            pm <= 16'h0000;
                            sa <= wa;
                        end
                        8'h50: sr <= sr & 7'h45;
                        8'h70: n_rs <= n_rs + 1;
                        default: ;
                    endcase
                    mode <= (ld[7:0] == 8'hFF) ? 2'd0 : (ld[7:0] == 8'hE8) ? 2'd2 : 2'd1;
                end
            endcase
        end
    end
endmodule // fwp_flash_model
`default_nettype wire

/* File: testbench/fwp_prog_ctrl_monitor.sv */
// Checker for the controller's user handshake and flash strobes.
// Assumes bind into fwp_prog_ctrl; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module fwp_prog_ctrl_monitor (
    input wire logic        i_clk,     // Clock
    input wire logic        i_arst_n,  // Reset, low
    input wire logic        i_start,   // Order
    input wire logic        o_busy,    // Busy
    input wire logic        o_done,    // Done
    input wire logic [7:0]  o_status,  // Status
    input wire logic        o_error,   // Error
    input wire logic        o_timeout, // Timeout
    input wire logic [15:0] o_dq_out,  // Data out
    input wire logic        o_dq_oe_n, // Drive, low
    input wire logic        o_ce_n,    // Chip enable
    input wire logic        o_we_n,    // Write enable
    input wire logic        o_oe_n     // Output enable
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    a_start_taken: assert property (i_start && !o_busy |=> o_busy)
        else $error("order not taken");
    a_done_pulse: assert property (o_done |=> !o_done && (!o_busy || $past(i_start)))
        else $error("done not a single pulse");
    a_error_flag: assert property (o_done && !o_timeout |-> o_error == (|{o_status[5:3], o_status[1]}))
        else $error("error flag disagrees with status");
    a_ready_seen: assert property (o_done && !o_timeout |-> o_status[7])
        else $error("finished before ready");
    a_write_drive: assert property (!o_we_n |-> !o_ce_n && o_oe_n && !o_dq_oe_n)
        else $error("write strobe without drive");
    a_we_width: assert property ($fell(o_we_n) |-> !o_we_n [*8])
        else $error("write strobe too short");
    a_data_hold: assert property ($rose(o_we_n) |-> $stable(o_dq_out) [*4])
        else $error("data not held after write");
    a_idle_bus: assert property (!o_busy && !o_done |-> o_ce_n && o_we_n && o_oe_n)
        else $error("bus active while idle");
endmodule // fwp_prog_ctrl_monitor
bind fwp_prog_ctrl fwp_prog_ctrl_monitor fwp_prog_ctrl_monitor_i (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_start(i_start), .o_busy(o_busy),
    .o_done(o_done), .o_status(o_status), .o_error(o_error), .o_timeout(o_timeout),
    .o_dq_out(o_dq_out), .o_dq_oe_n(o_dq_oe_n), .o_ce_n(o_ce_n), .o_we_n(o_we_n),
    .o_oe_n(o_oe_n)
);
`default_nettype wire

/* File: testbench/tb_fwp_prog_ctrl.sv */
// Testbench: program controller against a behavioural flash partition.
// Assumes the monitor is bound in by its own file.
`timescale 1ns/1ps
`default_nettype none
module tb_fwp_prog_ctrl;
    logic        clk = 1'b0, arst_n = 1'b0, start = 1'b0, bm = 1'b0, alt = 1'b0;
    logic        vpp_low = 1'b0, lock = 1'b0, fail = 1'b0;
    logic [1:0]  refuse = 2'd0;
    logic [3:0]  cnt_m1 = 4'h0;
    logic [22:0] addr = 23'h000000;
    logic [15:0] wdata = 16'h0000;
    wire logic [22:0] f_addr;
    wire logic [15:0] dq_out, fl_dq, dq_bus;
    wire logic [7:0]  status;
    wire logic        wready, busy, done, error, tmo, dq_oe_n, ce_n, we_n, oe_n;
    int          n_errors = 0;
    int          cmp_count = 0;
    assign dq_bus = dq_oe_n ? fl_dq : dq_out;
    fwp_prog_ctrl #(.MAX_POLLS(16'h0010)) fwp_prog_ctrl_i (
        .i_clk(clk), .i_arst_n(arst_n), .i_start(start), .i_buf_mode(bm),
        .i_alt_cmd(alt), .i_addr(addr), .i_count_m1(cnt_m1), .i_wdata(wdata),
        .o_wready(wready), .o_busy(busy), .o_done(done), .o_status(status),
        .o_error(error), .o_timeout(tmo), .i_dq_in(dq_bus), .o_f_addr(f_addr),
        .o_dq_out(dq_out), .o_dq_oe_n(dq_oe_n), .o_ce_n(ce_n), .o_we_n(we_n), .o_oe_n(oe_n)
    );
    fwp_flash_model #(.BUSY(120)) fwp_flash_model_i (
        .i_clk(clk), .i_addr(f_addr), .i_dq(dq_bus), .i_ce_n(ce_n), .i_we_n(we_n),
        .i_oe_n(oe_n), .i_vpp_low(vpp_low), .i_lock(lock), .i_fail(fail),
        .i_refuse(refuse), .o_dq(fl_dq)
    );
    initial forever #2 clk = ~clk;
    task automatic cmp(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("%0d compares, %0d mismatches", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic go(input logic b, input logic a, input logic [22:0] ad, input logic [3:0] c);
        @(negedge clk);
        {bm, alt, addr, cnt_m1, wdata, start} = {b, a, ad, c, 16'hA500, 1'b1};
        @(negedge clk);
        start = 1'b0;
    endtask
    task automatic finish_seq;
        logic nxt;
        nxt = 1'b0;
        for (int k = 0; k < 20000 && done !== 1'b1; k++) begin
            @(negedge clk);
            if (nxt) wdata = wdata + 16'h0001;
            nxt = (wready === 1'b1);
        end
        cmp(done, 1'b1);
        cmp(tmo, 1'b0);
    endtask
    task automatic t_word(input logic a, input logic [3:0] s);
        int r0;
        r0 = fwp_flash_model_i.n_rs;
        go(1'b0, a, {19'h00010, s}, 4'h0);
        finish_seq;
        cmp(fwp_flash_model_i.prog_cmd, a ? 16'h0010 : 16'h0040);
        cmp(fwp_flash_model_i.mem[s], 16'hA500);
        cmp(status, 16'h0080);
        cmp(fwp_flash_model_i.mode, 16'h0000);
        cmp(fwp_flash_model_i.n_rs - r0, 16'h0001);
        $display("word program test done");
    endtask
    task automatic t_err;
        for (int e = 0; e < 3; e++) begin
            {vpp_low, lock, fail} = 3'b100 >> e;
            go(1'b0, 1'b0, 23'h00010C, 4'h0);
            finish_seq;
            cmp(status, e == 0 ? 16'h0098 : e == 1 ? 16'h0092 : 16'h0090);
            cmp(error, 1'b1);
            cmp(fwp_flash_model_i.sr, 16'h0000);
            cmp(fwp_flash_model_i.mem[12], e == 2 ? 16'hA500 : 16'h0000);
        end
        {vpp_low, lock, fail} = 3'b000;
        $display("error test done");
    endtask
    task automatic t_buf(input logic [1:0] r, input logic [3:0] s, input logic [3:0] c);
        logic [7:0] n0;
        int         b0;
        n0 = fwp_flash_model_i.n_e8;
        b0 = fwp_flash_model_i.n_busy;
        refuse = r;
        go(1'b1, 1'b0, {19'h00020, s}, c);
        finish_seq;
        cmp(fwp_flash_model_i.n_e8 - n0, r + 16'h0001);
        cmp(fwp_flash_model_i.cnt, {12'h000, c});
        for (int j = 0; j <= c; j++) cmp(fwp_flash_model_i.mem[(s + j) % 16], 16'hA500 + j);
        cmp(status, 16'h0080);
        cmp(fwp_flash_model_i.n_busy > b0, 1'b1);
        $display("buffer program test done");
    endtask
    task automatic t_refuse;
        logic [7:0] n0;
        n0 = fwp_flash_model_i.n_e8;
        go(1'b0, 1'b1, 23'h000107, 4'h0);
        go(1'b1, 1'b0, 23'h000200, 4'hF);
        finish_seq;
        cmp(fwp_flash_model_i.n_e8, n0);
        cmp(fwp_flash_model_i.prog_cmd, 16'h0010);
        $display("refused order test done");
    endtask
    initial begin
        repeat (5) @(posedge clk);
        @(negedge clk);
        arst_n = 1'b1;
        t_word(1'b0, 4'h5);
        t_word(1'b1, 4'h6);
        t_err;
        t_buf(2'd2, 4'h3, 4'hF);
        t_buf(2'd0, 4'hA, 4'h0);
        t_refuse;
        close_out;
    end
    initial begin
        #80000;
        n_errors++;
        $display("unexpected at %0t: watchdog expired", $time);
        close_out;
    end
endmodule // tb_fwp_prog_ctrl
`default_nettype wire
